// ===== common/pldpd_defs.svh
// Constants for the programmable logic power-down and configuration block
`ifndef PLDPD_DEFS_SVH
`define PLDPD_DEFS_SVH
`define PLDPD_CLK_PERIOD_NS 40
`define PLDPD_POR_TIME_NS 1000
`define PLDPD_POR_CYCLES (`PLDPD_POR_TIME_NS / `PLDPD_CLK_PERIOD_NS)
`define PLDPD_NUM_IN 12
`define PLDPD_NUM_MC 10
`define PLDPD_SIG_BITS 64
`define PLDPD_SLEEP_IN_IDX 3
`define PLDPD_REG_RESET 1'b0
`define PLDPD_CFG_BITS 2
`define PLDPD_CFG_POL 0
`define PLDPD_CFG_REGD 1
`endif

// ===== common/pldpd_pkg.sv
// Types for the programmable logic power-down and configuration block
package pldpd_pkg;
	typedef enum logic [1:0] {
		PLDPD_ST_POR  = 2'b00,
		PLDPD_ST_RUN  = 2'b01,
		PLDPD_ST_SLP  = 2'b10
	} pldpd_state_t;
	typedef enum logic [1:0] {
		PLDPD_MODE_COMB_HI = 2'b00,
		PLDPD_MODE_COMB_LO = 2'b01,
		PLDPD_MODE_REG_HI  = 2'b10,
		PLDPD_MODE_REG_LO  = 2'b11
	} pldpd_mode_t;
endpackage

// ===== core/pldpd_core.sv
// Macrocell array with power-up reset, preload, signature, security and sleep
`include "pldpd_defs.svh"

// Notes on behaviour
// RULE_01: After power-up all macrocell registers clear low within 1000 ns.
// RULE_02: After reset each output shows the cleared register through its polarity; only registered-mode cells do this, combinational cells show mc_func.
// RULE_03: Board logic keeps the clock free of edges during power-up reset.
// RULE_04: Board logic meets setup before the first clock edge after reset.
// RULE_05: Test preload may force each register high or low.
// RULE_06: The 64-bit user signature is always readable, secured or not.
// RULE_07: Security set at once refuses configuration readback and preload.
// RULE_08: Programmers should set the security bit last.
// RULE_09: Undriven inputs and I/O pins hold their last driven level weakly.
// RULE_10: Sleep high with sleep enabled freezes all logic and outputs.
// RULE_11: An undetermined output stays the same throughout sleep.
// RULE_12: During sleep all inputs except the sleep pin are blocked.
// RULE_13: Pin hold latches stay active during sleep.
// RULE_14: Sleep only works with its enable bit; else pin is plain input.
// RULE_15: With sleep enabled the shared pin array input reads zero.
// RULE_16: Twelve dedicated inputs and ten bidirectional macrocells.
// RULE_17: Each macrocell picks polarity and registered or combinational mode.
// RULE_18: Sleep freezes clocking and outputs at once, resumes when released.
module pldpd_core
	import pldpd_pkg::*;
#(
	parameter int NUM_IN  = `PLDPD_NUM_IN,
	parameter int NUM_MC  = `PLDPD_NUM_MC,
	parameter int SIG_W   = `PLDPD_SIG_BITS
) (
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	input  wire logic [NUM_IN-1:0]     in_pin_i,
	input  wire logic [NUM_IN-1:0]     in_pin_drv,
	input  wire logic [NUM_MC-1:0]     io_pin_i,
	input  wire logic [NUM_MC-1:0]     io_pin_drv,
	output logic      [NUM_MC-1:0]     io_pin_o,
	output logic      [NUM_MC-1:0]     io_pin_oe,
	input  wire logic [NUM_MC-1:0]     mc_func,
	input  wire logic [NUM_MC-1:0]     mc_oe_func,
	input  wire logic [2*NUM_MC-1:0]   mc_mode,
	input  wire logic                  sleep_enable,
	input  wire logic                  preload_req,
	input  wire logic [NUM_MC-1:0]     preload_val,
	input  wire logic                  secure_prog,
	input  wire logic                  sig_wr,
	input  wire logic [SIG_W-1:0]      sig_wdata,
	output logic      [SIG_W-1:0]      sig_rdata,
	input  wire logic                  verify_req,
	output logic      [2*NUM_MC-1:0]   verify_data,
	output logic                       verify_refused,
	output logic                       por_busy,
	output logic                       sleeping,
	output logic      [NUM_IN-1:0]     array_in,
	output logic      [NUM_MC-1:0]     mc_feedback,
	output logic      [NUM_MC-1:0]     mc_reg_q
);
	import pldpd_pkg::*;

	localparam int POR_CYC = (`PLDPD_POR_CYCLES < 1) ? 1 : `PLDPD_POR_CYCLES;
	localparam int CW = $clog2(POR_CYC + 1);

	// ----------------------------------------
	// Power-up reset sequencing
	// ----------------------------------------
	pldpd_state_t    state_r;
	logic [CW-1:0]   por_cnt_r;
	logic            secure_r;
	logic [NUM_IN-1:0] in_keep_r;
	logic [NUM_MC-1:0] io_keep_r;
	logic [NUM_MC-1:0] out_hold_r;
	logic [NUM_MC-1:0] oe_hold_r;
	logic [NUM_IN-1:0] in_eff;
	logic [NUM_MC-1:0] io_eff;
	logic [NUM_MC-1:0] out_live;
	logic [NUM_MC-1:0] oe_live;
	logic              sleep_raw;
	logic              frozen;
	logic [NUM_MC-1:0] io_own;
	logic [NUM_MC-1:0] cfg_low;
	logic [NUM_MC-1:0] cfg_reg;

	// Interval of exactly 1000 ns, 25 cycles of the 40 ns clock
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_r <= '0;
		end else if (state_r == PLDPD_ST_POR) begin
			por_cnt_r <= por_cnt_r + CW'(1); // see RULE_01
		end
	end

	// ----------------------------------------
	// Pin keepers
	// ----------------------------------------
	// Keepers run even during sleep so pins never float
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_keep_r <= '0;
			io_keep_r <= '0;
		end else begin
			in_keep_r <= in_eff; // see RULE_09 see RULE_13
			io_keep_r <= io_eff; // see RULE_09 see RULE_13
		end
	end

	assign in_eff = (in_pin_drv & in_pin_i) | (~in_pin_drv & in_keep_r); // see RULE_09
	// Own driven outputs count as driving the pin
	// Chosen bit by bit, so one enabled cell cannot steer the others
	assign io_own = (io_pin_oe & io_pin_o) | (~io_pin_oe & io_pin_i);
	assign io_eff = ((io_pin_drv | io_pin_oe) & io_own)
		| (~(io_pin_drv | io_pin_oe) & io_keep_r); // see RULE_09

	// ----------------------------------------
	// Sleep control
	// ----------------------------------------
	assign sleep_raw = sleep_enable & in_eff[`PLDPD_SLEEP_IN_IDX]; // see RULE_14
	assign frozen    = sleep_raw & (state_r != PLDPD_ST_POR); // see RULE_18
	assign sleeping  = frozen;
	assign por_busy  = (state_r == PLDPD_ST_POR);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= PLDPD_ST_POR;
		end else begin
			unique case (state_r)
				PLDPD_ST_POR: begin
					if (por_cnt_r == CW'(POR_CYC - 1)) begin
						state_r <= PLDPD_ST_RUN;
					end
				end
				PLDPD_ST_RUN: begin
					if (frozen) begin
						state_r <= PLDPD_ST_SLP;
					end
				end
				PLDPD_ST_SLP: begin
					if (!frozen) begin
						state_r <= PLDPD_ST_RUN;
					end
				end
				default: begin
					state_r <= PLDPD_ST_POR;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Array inputs, blocked while asleep
	// ----------------------------------------
	logic [NUM_IN-1:0] in_latched_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_latched_r <= '0;
		end else if (!frozen) begin
			in_latched_r <= in_eff;
		end
	end

	always_comb begin
		array_in = frozen ? in_latched_r : in_eff; // see RULE_12
		if (sleep_enable) begin
			array_in[`PLDPD_SLEEP_IN_IDX] = 1'b0; // see RULE_15
		end
	end

	// ----------------------------------------
	// Macrocells
	// ----------------------------------------
	function automatic logic mc_is_reg(input logic [1:0] m);
		return m[`PLDPD_CFG_REGD];
	endfunction

	function automatic logic mc_is_low(input logic [1:0] m);
		return m[`PLDPD_CFG_POL];
	endfunction

	// Security acts in its own cycle, for preload as for readback
	logic preload_ok;
	assign preload_ok = preload_req & ~secure_r & ~secure_prog; // see RULE_07

	genvar g;
	generate
		for (g = 0; g < NUM_MC; g++) begin : g_mc // see RULE_16
			logic [`PLDPD_CFG_BITS-1:0] m;
			logic                       src;
			logic                       q_r;
			assign m = mc_mode[`PLDPD_CFG_BITS*g +: `PLDPD_CFG_BITS];

			// Register kept per cell so each output bit has a single driver
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					q_r <= `PLDPD_REG_RESET;
				end else if (state_r == PLDPD_ST_POR) begin
					q_r <= `PLDPD_REG_RESET; // see RULE_01
				end else if (frozen) begin
					q_r <= q_r; // see RULE_10 see RULE_18
				end else if (preload_ok) begin
					q_r <= preload_val[g]; // see RULE_05
				end else begin
					q_r <= mc_func[g];
				end
			end

			assign mc_reg_q[g]    = q_r;
			assign cfg_reg[g]     = mc_is_reg(m);
			assign cfg_low[g]     = mc_is_low(m);
			assign src = mc_is_reg(m) ? q_r : mc_func[g]; // see RULE_17
			assign out_live[g] = src ^ mc_is_low(m); // see RULE_02 see RULE_17
			assign oe_live[g]  = mc_oe_func[g] & (state_r != PLDPD_ST_POR);
			assign mc_feedback[g] = q_r; // see RULE_15
		end
	endgenerate

	// Output hold captures whatever level was present, known or not
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_hold_r <= '0;
			oe_hold_r  <= '0;
		end else if (!frozen) begin
			out_hold_r <= out_live;
			oe_hold_r  <= oe_live;
		end
	end

	assign io_pin_o  = frozen ? out_hold_r : out_live; // see RULE_10 see RULE_11
	assign io_pin_oe = frozen ? oe_hold_r : oe_live; // see RULE_10

	// ----------------------------------------
	// Security and user signature
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			secure_r <= 1'b0;
		end else if (secure_prog) begin
			secure_r <= 1'b1; // see RULE_07
		end
	end

	logic [SIG_W-1:0] sig_r;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sig_r <= '0;
		end else if (sig_wr && !secure_r) begin
			sig_r <= sig_wdata;
		end
	end
	assign sig_rdata = sig_r; // see RULE_06

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			verify_data    <= '0;
			verify_refused <= 1'b0;
		end else begin
			verify_refused <= verify_req & (secure_r | secure_prog);
			if (verify_req && !(secure_r || secure_prog)) begin
				verify_data <= mc_mode; // see RULE_07
			end else begin
				verify_data <= '0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_por_done;
		$fell(por_busy);
	endsequence

	// Polarity is checked against the mode bits, not the output path itself
	a_por_clears: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_01
		por_busy |=> mc_reg_q == '0)
		else $error("register not cleared in power-up reset");
	a_por_bound: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_01
		$rose(arst_n) |-> ##[0:POR_CYC] !por_busy)
		else $error("power-up reset too long");
	a_out_after_por: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_02
		s_por_done |-> ((io_pin_o ^ cfg_low) & cfg_reg) == '0)
		else $error("output wrong after reset");
	a_preload_force: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_05
		(preload_ok && !frozen && !por_busy) |=> mc_reg_q == $past(preload_val))
		else $error("preload not applied");
	a_secure_block: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_07
		(secure_r && verify_req) |=> verify_refused && verify_data == '0)
		else $error("readback allowed while secured");
	a_sig_open: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_06
		(sig_wr && !secure_r) |=> sig_rdata == $past(sig_wdata))
		else $error("signature write not readable");
	a_sig_locked: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_06
		secure_r |=> $stable(sig_rdata))
		else $error("signature changed while secured");
	a_sleep_freeze: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_10
		(frozen && $past(frozen)) |-> $stable(mc_reg_q) && $stable(io_pin_o))
		else $error("state moved during sleep");
	a_sleep_block: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_12
		(frozen && $past(frozen)) |-> $stable(array_in))
		else $error("input passed during sleep");
	a_sleep_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_14
		!sleep_enable |-> !sleeping)
		else $error("sleep without enable");
	a_pin_masked: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE_15
		sleep_enable |-> !array_in[`PLDPD_SLEEP_IN_IDX])
		else $error("shared pin reached array");
endmodule

// ===== sim/pldpd_board.sv
// Board-side model: input pins and a simple logic array for the macrocells
module pldpd_board (
	input  wire logic        core_clk,
	input  wire logic [11:0] ext_in,
	input  wire logic [11:0] ext_in_en,
	input  wire logic [11:0] array_in,
	output logic      [11:0] in_pin_i,
	output logic      [11:0] in_pin_drv,
	output logic      [9:0]  mc_func,
	output logic      [9:0]  mc_oe_func
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] last_r;
	always_ff @(posedge core_clk) begin
		last_r <= (ext_in & ext_in_en) | (last_r & ~ext_in_en);
	end
	// Released pins show the inverse level, so only the keeper can hold them
	assign in_pin_i   = (ext_in & ext_in_en) | (~last_r & ~ext_in_en);
	assign in_pin_drv = ext_in_en;
	// Each cell simply follows its own gated input
	assign mc_func    = array_in[9:0];
	assign mc_oe_func = 10'h3FF;
endmodule

// ===== sim/pld_power_down_and_config_test.sv
// Self-checking bench for the power-down and configuration block
`include "pldpd_defs.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module pld_power_down_and_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [11:0] ext_in = 12'h000;
	logic [11:0] ext_in_en = 12'hFFF;
	logic [11:0] in_pin_i, in_pin_drv, array_in;
	logic [9:0]  mc_func, mc_oe_func, io_pin_o, io_pin_oe, mc_feedback, mc_reg_q;
	logic [9:0]  preload_val = 10'h000;
	logic [19:0] mc_mode = 20'hFFFFF;
	logic [19:0] verify_data;
	logic        sleep_enable = 1'b0, preload_req = 1'b0, secure_prog = 1'b0;
	logic        sig_wr = 1'b0, verify_req = 1'b0, verify_refused, por_busy, sleeping;
	logic [63:0] sig_wdata = 64'h0, sig_rdata;
	int          errors = 0, cmp_count = 0, n;
	// ----
	// Rows: cell mode, input pins, expected pin levels
	// ----
	logic [1:0]  row_mode [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic [11:0] row_in   [4] = '{12'hA5C, 12'hA5C, 12'h3F0, 12'h155};
	logic [9:0]  row_out  [4] = '{10'h25C, 10'h1A3, 10'h3F0, 10'h2AA};

	always #20 core_clk = ~core_clk;

	pldpd_board pldpd_board_i (.core_clk(core_clk), .ext_in(ext_in), .ext_in_en(ext_in_en),
		.array_in(array_in), .in_pin_i(in_pin_i), .in_pin_drv(in_pin_drv),
		.mc_func(mc_func), .mc_oe_func(mc_oe_func));
	pldpd_core pldpd_core_i (.core_clk(core_clk), .arst_n(arst_n), .in_pin_i(in_pin_i),
		.in_pin_drv(in_pin_drv), .io_pin_i(10'h000), .io_pin_drv(10'h000),
		.io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe), .mc_func(mc_func),
		.mc_oe_func(mc_oe_func), .mc_mode(mc_mode), .sleep_enable(sleep_enable),
		.preload_req(preload_req), .preload_val(preload_val), .secure_prog(secure_prog),
		.sig_wr(sig_wr), .sig_wdata(sig_wdata), .sig_rdata(sig_rdata),
		.verify_req(verify_req), .verify_data(verify_data),
		.verify_refused(verify_refused), .por_busy(por_busy), .sleeping(sleeping),
		.array_in(array_in), .mc_feedback(mc_feedback), .mc_reg_q(mc_reg_q));

	task automatic cyc();
		@(posedge core_clk);
		#1;
	endtask
	task automatic done(string s);
		$display("test %s ended, mismatches %0d", s, errors);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Generous span, the sequence needs well under 100 cycles
	initial begin
		#10000;
		errors++;
		tally_and_finish();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		n = 0;
		while (por_busy === 1'b1 && n < 40) begin
			cyc();
			n++;
		end
		`CHK(n >= `PLDPD_POR_CYCLES - 1 && n <= `PLDPD_POR_CYCLES, 1'b1)
		`CHK(mc_reg_q, 10'h000)
		`CHK(io_pin_o, 10'h3FF)
		done("reset");
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk);
			mc_mode <= {10{row_mode[i]}};
			ext_in <= row_in[i];
			cyc();
			`CHK(io_pin_o, row_out[i])
			`CHK(io_pin_oe, 10'h3FF)
			`CHK(sleeping, 1'b0)
			`CHK(array_in, row_in[i])
			if (row_mode[i][1]) `CHK(mc_reg_q, row_in[i][9:0])
		end
		done("modes");
		@(posedge core_clk);
		ext_in <= 12'h5A1;
		@(posedge core_clk);
		ext_in_en <= 12'h000;
		cyc();
		cyc();
		`CHK(array_in, 12'h5A1)
		`CHK(mc_reg_q, 10'h1A1)
		done("keeper");
		@(posedge core_clk);
		ext_in_en <= 12'hFFF;
		sleep_enable <= 1'b1;
		mc_mode <= 20'hAAAAA;
		ext_in <= 12'h0F7;
		cyc();
		`CHK(mc_reg_q, 10'h0F7)
		@(posedge core_clk);
		ext_in <= 12'h30C;
		#1;
		`CHK(sleeping, 1'b1)
		`CHK(array_in[3], 1'b0)
		repeat (3) cyc();
		`CHK(mc_reg_q, 10'h0F7)
		`CHK(io_pin_o, 10'h0F7)
		@(posedge core_clk);
		ext_in <= 12'h300;
		cyc();
		`CHK(sleeping, 1'b0)
		`CHK(mc_reg_q, 10'h300)
		done("sleep");
		@(posedge core_clk);
		preload_req <= 1'b1;
		preload_val <= 10'h2A5;
		sig_wr <= 1'b1;
		sig_wdata <= 64'h0123456789ABCDEF;
		verify_req <= 1'b1;
		cyc();
		`CHK(mc_reg_q, 10'h2A5)
		`CHK(verify_data, 20'hAAAAA)
		`CHK(verify_refused, 1'b0)
		`CHK(sig_rdata, 64'h0123456789ABCDEF)
		@(posedge core_clk);
		preload_val <= 10'h15A;
		sig_wr <= 1'b0;
		verify_req <= 1'b0;
		cyc();
		`CHK(mc_reg_q, 10'h15A)
		@(posedge core_clk);
		preload_req <= 1'b0;
		secure_prog <= 1'b1;
		verify_req <= 1'b1;
		cyc();
		`CHK(verify_refused, 1'b1)
		`CHK(verify_data, 20'h00000)
		@(posedge core_clk);
		secure_prog <= 1'b0;
		verify_req <= 1'b0;
		preload_req <= 1'b1;
		preload_val <= 10'h3C3;
		sig_wr <= 1'b1;
		sig_wdata <= 64'hFEDCBA9876543210;
		ext_in <= 12'h111;
		cyc();
		`CHK(mc_reg_q, 10'h111)
		`CHK(sig_rdata, 64'h0123456789ABCDEF)
		`CHK(verify_refused, 1'b0)
		@(posedge core_clk);
		preload_req <= 1'b0;
		sig_wr <= 1'b0;
		done("security");
		tally_and_finish();
	end
endmodule
